// ==== design/sad_pkg.sv ====
package sad_pkg;
  // Register byte offsets, one aligned word each
  localparam logic [7:0] SAD_OFF_CTRL   = 8'h00;
  localparam logic [7:0] SAD_OFF_SRC_A  = 8'h04;
  localparam logic [7:0] SAD_OFF_SRC_B  = 8'h08;
  localparam logic [7:0] SAD_OFF_RESULT = 8'h0c;
  localparam logic [7:0] SAD_OFF_STATUS = 8'h10;
  // Control field positions
  localparam int SAD_CTRL_OP_LSB   = 0;
  localparam int SAD_CTRL_LANE_LSB = 4;
  localparam int SAD_CTRL_SIGNED   = 6;
  localparam int SAD_CTRL_GO       = 8;
  localparam int SAD_CTRL_BUSY     = 9;
  // Status field positions
  localparam int SAD_ST_CARRY   = 0;
  localparam int SAD_ST_OVF     = 1;
  localparam int SAD_ST_ZERO    = 2;
  localparam int SAD_ST_SEG_LSB = 4;
  // Operation codes
  localparam logic [3:0] SAD_OP_ADD   = 4'h0;
  localparam logic [3:0] SAD_OP_SUB   = 4'h1;
  localparam logic [3:0] SAD_OP_RMO   = 4'h2;
  localparam logic [3:0] SAD_OP_RMBC  = 4'h3;
  localparam logic [3:0] SAD_OP_LCHG  = 4'h4;
  localparam logic [3:0] SAD_OP_MASK  = 4'h5;
  localparam logic [3:0] SAD_OP_SMUL  = 4'h6;
  // Lane size codes for alu_lane_size
  localparam logic [1:0] SAD_LANE_WORD = 2'h0;
  localparam logic [1:0] SAD_LANE_HALF = 2'h1;
  localparam logic [1:0] SAD_LANE_BYTE = 2'h2;
  // Reset value, and the position reported when no bit qualifies
  localparam logic [31:0] SAD_RST_WORD = 32'h0000_0000;
  localparam logic [5:0]  SAD_NO_POS   = 6'h20;

  // Whole state of the block
  typedef struct packed {
    logic [3:0]  op;            // Selected operation
    logic [1:0]  lane;          // alu_lane_size
    logic        mul_signed;    // Second factor signed in split multiply
    logic [31:0] src_a;         // First operand
    logic [31:0] src_b;         // Second operand
    logic [31:0] result;        // Result register
    logic        carry;         // Full-word carry out
    logic        ovf;           // Overflow status
    logic        zero;          // Result is zero
    logic [3:0]  seg_flags;     // segment_flag_register
    logic        pending;       // Operation runs this cycle
    logic        wr_ph;         // Write data phase in progress
    logic [7:0]  wr_addr;       // Address of that write
    logic [31:0] rdata;         // Registered read data
  } sad_state_s;
endpackage : sad_pkg

// ==== design/sad_top.sv ====
// The AHB-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
// How it works
// [RL1] Lane boundaries block carry in multiple arithmetic
// [RL2] Each lane saves carry-out or zero
// [RL3] Byte lanes cut carry at 24, 16, 8
// [RL4] Halfword lanes cut carry at 16 only
// [RL5] Rightmost change gives lowest bit unlike bit0
// [RL6] Rightmost change flags overflow when all equal
// [RL7] Rightmost one gives lowest set bit position
// [RL8] Split multiply gives two 8x8 products
// [RL9] Split factors unsigned-unsigned or unsigned-signed
// [RL10] Software register write beats hardware update
// [RL11] Mask generator sets n low bits
// [RL12] Leftmost change gives highest bit unlike sign
// [RL13] Lane 0 holds lowest byte or halfword flag
module sad_top
  import sad_pkg::*;
(
  input  wire logic        hclk,       // Core clock, 100 MHz
  input  wire logic        hresetn,    // Asynchronous reset, active low
  input  wire logic        hsel,       // Slave select
  input  wire logic [31:0] haddr,      // Byte address
  input  wire logic [1:0]  htrans,     // Transfer type
  input  wire logic        hwrite,     // Write when high
  input  wire logic [2:0]  hsize,      // Transfer size
  input  wire logic        hready,     // Bus ready in
  input  wire logic [31:0] hwdata,     // Write data
  output logic      [31:0] hrdata,     // Read data
  output logic             hreadyout,  // Slave ready
  output logic             hresp       // Response, always OKAY
);

  sad_state_s s_reg;   // Registered state
  sad_state_s s_next;  // Next state

  // Lowest set bit, or SAD_NO_POS when none
  function automatic logic [5:0] low_one(input logic [31:0] x);
    logic [5:0] p;
    p = SAD_NO_POS;
    for (int i = 31; i >= 0; i--) begin
      if (x[i]) begin
        p = 6'(i);
      end
    end
    return p;
  endfunction : low_one

  // Highest set bit, or SAD_NO_POS when none
  function automatic logic [5:0] high_one(input logic [31:0] x);
    logic [5:0] p;
    p = SAD_NO_POS;
    for (int i = 0; i < 32; i++) begin
      if (x[i]) begin
        p = 6'(i);
      end
    end
    return p;
  endfunction : high_one

  // Operand routing for the adder
  logic        is_sub;      // Subtract selected
  logic [31:0] b_op;        // Second operand, inverted on subtract
  logic [3:0]  cut;         // Carry blocked above this byte lane
  logic [4:0]  lane_cin;    // Carry into each byte lane
  logic [8:0]  lane_sum [4];// Byte lane sums with carry out
  logic [31:0] sum_w;       // Adder result

  assign is_sub = (s_reg.op == SAD_OP_SUB);
  assign b_op   = is_sub ? ~s_reg.src_b : s_reg.src_b;
  // Byte mode cuts every boundary, halfword only the middle one
  assign cut[0] = (s_reg.lane == SAD_LANE_BYTE);                          // see [RL3]
  assign cut[1] = (s_reg.lane == SAD_LANE_BYTE) | (s_reg.lane == SAD_LANE_HALF); // see [RL4]
  assign cut[2] = (s_reg.lane == SAD_LANE_BYTE);                          // see [RL3]
  assign cut[3] = 1'b0;
  assign lane_cin[0] = is_sub;

  // One byte adder per lane; a cut lane restarts with the op's carry-in
  for (genvar g = 0; g < 4; g++) begin : g_lane
    assign lane_sum[g] = {1'b0, s_reg.src_a[8*g +: 8]} + {1'b0, b_op[8*g +: 8]}
                         + {8'h00, lane_cin[g]};
    assign lane_cin[g+1] = cut[g] ? is_sub : lane_sum[g][8]; // see [RL1]
    assign sum_w[8*g +: 8] = lane_sum[g][7:0];
  end

  // Bit detection sources
  logic [31:0] rmbc_src;   // Bits unlike bit 0
  logic [31:0] lchg_src;   // Bits unlike the sign bit
  logic [5:0]  rmo_pos;    // Rightmost one position
  logic [5:0]  rmbc_pos;   // Rightmost change position
  logic [5:0]  lchg_pos;   // leftmost_change_position
  logic [31:0] mask_w;     // Generated mask

  assign rmbc_src = s_reg.src_a ^ {32{s_reg.src_a[0]}};   // Bit 0 always clear
  assign lchg_src = {1'b0, s_reg.src_a[30:0] ^ {31{s_reg.src_a[31]}}};
  assign rmo_pos  = low_one(s_reg.src_a);                 // see [RL7]
  assign rmbc_pos = low_one(rmbc_src);                    // see [RL5]
  assign lchg_pos = high_one(lchg_src);                   // see [RL12]
  assign mask_w   = (32'h0000_0001 << s_reg.src_b[4:0]) - 32'h0000_0001; // see [RL11]

  // Split multiply, two independent 8x8 products
  logic [15:0] prod [2];   // Low and high lane products

  for (genvar m = 0; m < 2; m++) begin : g_mul
    logic signed [16:0] sp;  // Unsigned by signed product
    logic        [15:0] up;  // Unsigned by unsigned product
    // Factors widened first so no product bits are lost
    assign up = {8'h00, s_reg.src_a[8*m +: 8]} * {8'h00, s_reg.src_b[8*m +: 8]}; // see [RL8]
    assign sp = $signed({1'b0, s_reg.src_a[8*m +: 8]}) * $signed(s_reg.src_b[8*m +: 8]);
    // Signed form fits 16 bits: range is -32640 to 32385
    assign prod[m] = s_reg.mul_signed ? sp[15:0] : up;   // see [RL9]
  end

  // Hardware result and flags of the selected operation
  logic [31:0] hw_res;   // Result value
  logic        hw_carry; // Full-word carry
  logic        hw_ovf;   // Overflow
  logic [3:0]  hw_seg;   // Lane flags
  logic        split;    // Multiple arithmetic active

  assign split = (s_reg.lane == SAD_LANE_BYTE) | (s_reg.lane == SAD_LANE_HALF);

  // Operation mux
  always_comb begin
    hw_res   = SAD_RST_WORD;
    hw_carry = 1'b0;
    hw_ovf   = 1'b0;
    hw_seg   = 4'h0;   // Zero unless a lane carry applies, see [RL2]
    case (s_reg.op)
      SAD_OP_ADD, SAD_OP_SUB: begin
        hw_res   = sum_w;
        hw_carry = lane_cin[4];
        // Lane 0 is the lowest byte or halfword
        if (s_reg.lane == SAD_LANE_BYTE) begin
          hw_seg = {lane_sum[3][8], lane_sum[2][8], lane_sum[1][8], lane_sum[0][8]}; // see [RL13]
        end else if (s_reg.lane == SAD_LANE_HALF) begin
          hw_seg = {2'b00, lane_sum[3][8], lane_sum[1][8]};                      // see [RL13]
        end
      end
      SAD_OP_RMO: begin
        hw_res = {26'h0, rmo_pos};
      end
      SAD_OP_RMBC: begin
        hw_res = {26'h0, rmbc_pos};
        hw_ovf = (rmbc_src == SAD_RST_WORD);   // No change exists, see [RL6]
      end
      SAD_OP_LCHG: begin
        hw_res = {26'h0, lchg_pos};
        hw_ovf = (lchg_src == SAD_RST_WORD);
      end
      SAD_OP_MASK: begin
        hw_res = mask_w;
      end
      SAD_OP_SMUL: begin
        hw_res = {prod[1], prod[0]};
      end
      default: begin
        hw_res = SAD_RST_WORD;
      end
    endcase
  end

  // Bus decode
  logic        ap_valid;  // Address phase accepted this cycle
  logic        sw_wr;     // Write data phase this cycle
  logic        sw_res;    // Software write to result
  logic        sw_st;     // Software write to status

  assign ap_valid = hsel & htrans[1] & hready;
  assign sw_wr    = s_reg.wr_ph;
  assign sw_res   = sw_wr & (s_reg.wr_addr == SAD_OFF_RESULT);
  assign sw_st    = sw_wr & (s_reg.wr_addr == SAD_OFF_STATUS);

  // Next state: hardware update first, software write after so it wins
  always_comb begin
    s_next = s_reg;
    s_next.pending = 1'b0;
    // Hardware update one cycle after go
    if (s_reg.pending) begin
      s_next.result = hw_res;
      s_next.zero   = (hw_res == SAD_RST_WORD);
      s_next.carry  = hw_carry;
      s_next.ovf    = hw_ovf;
      if (split) begin
        s_next.seg_flags = hw_seg;   // Word mode keeps the lane flags
      end
    end
    // Software write in data phase
    if (sw_wr) begin
      if (s_reg.wr_addr == SAD_OFF_CTRL) begin
        s_next.op         = hwdata[SAD_CTRL_OP_LSB +: 4];
        s_next.lane       = hwdata[SAD_CTRL_LANE_LSB +: 2];
        s_next.mul_signed = hwdata[SAD_CTRL_SIGNED];
        s_next.pending    = hwdata[SAD_CTRL_GO];
      end else if (s_reg.wr_addr == SAD_OFF_SRC_A) begin
        s_next.src_a = hwdata;
      end else if (s_reg.wr_addr == SAD_OFF_SRC_B) begin
        s_next.src_b = hwdata;
      end else if (s_reg.wr_addr == SAD_OFF_RESULT) begin
        s_next.result = hwdata;   // see [RL10]
      end else if (s_reg.wr_addr == SAD_OFF_STATUS) begin
        s_next.carry = hwdata[SAD_ST_CARRY];   // see [RL10]
        s_next.ovf   = hwdata[SAD_ST_OVF];
        s_next.zero  = hwdata[SAD_ST_ZERO];
        s_next.seg_flags = hwdata[SAD_ST_SEG_LSB +: 4];
      end
    end
    // Latch address phase; only word transfers are expected
    s_next.wr_ph   = ap_valid & hwrite;
    s_next.wr_addr = haddr[7:0];
    // Read data taken from next values so a same-cycle update is seen
    if (ap_valid & ~hwrite) begin
      if (haddr[7:0] == SAD_OFF_CTRL) begin
        s_next.rdata = {22'h0, s_next.pending, 2'b00, s_next.mul_signed, s_next.lane,
                        s_next.op};
      end else if (haddr[7:0] == SAD_OFF_SRC_A) begin
        s_next.rdata = s_next.src_a;
      end else if (haddr[7:0] == SAD_OFF_SRC_B) begin
        s_next.rdata = s_next.src_b;
      end else if (haddr[7:0] == SAD_OFF_RESULT) begin
        s_next.rdata = s_next.result;
      end else if (haddr[7:0] == SAD_OFF_STATUS) begin
        s_next.rdata = {24'h0, s_next.seg_flags, 1'b0, s_next.zero, s_next.ovf, s_next.carry};
      end else begin
        s_next.rdata = SAD_RST_WORD;   // Unmapped reads as zero
      end
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs; zero wait states, always OKAY
  assign hrdata    = s_reg.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence seq_run(logic [3:0] o);
    s_reg.pending && s_reg.op == o;
  endsequence

  sequence seq_hw_res;
    !sw_res;
  endsequence

  a_byte_lane_cut: assert property ( // see [RL3]
    seq_run(SAD_OP_ADD) and (s_reg.lane == SAD_LANE_BYTE) |->
      sum_w[15:8] == 8'(s_reg.src_a[15:8] + s_reg.src_b[15:8]))
    else $error("byte lane carry leaked");

  a_half_lane_cut: assert property ( // see [RL4]
    seq_run(SAD_OP_ADD) and (s_reg.lane == SAD_LANE_HALF) |->
      sum_w[31:16] == 16'(s_reg.src_a[31:16] + s_reg.src_b[31:16]) &&
      sum_w[15:8] == 8'(17'({s_reg.src_a[15:0]} + {s_reg.src_b[15:0]}) >> 8))
    else $error("halfword carry cut wrong");

  // Upper lane must see no carry from below in either split size
  a_lane_indep: assert property ( // see [RL1]
    s_reg.pending && split && !is_sub |->
      sum_w[31:24] == ((s_reg.lane == SAD_LANE_BYTE) ?
        8'(s_reg.src_a[31:24] + s_reg.src_b[31:24]) :
        8'(17'({1'b0, s_reg.src_a[31:16]} + {1'b0, s_reg.src_b[31:16]}) >> 8)))
    else $error("upper lane sum wrong");

  // Lane flags: carry of lane 1 after byte add
  a_seg_carry: assert property ( // see [RL13]
    seq_run(SAD_OP_ADD) and (s_reg.lane == SAD_LANE_BYTE) and !sw_st |=>
      s_reg.seg_flags[1] ==
      $past(9'({1'b0, s_reg.src_a[15:8]} + {1'b0, s_reg.src_b[15:8]}) >> 8))
    else $error("lane 1 flag is not its carry");

  // Halfword mode uses only the two low flag bits
  a_half_flag_hi: assert property ( // see [RL13]
    seq_run(SAD_OP_ADD) and (s_reg.lane == SAD_LANE_HALF) and !sw_st |=>
      s_reg.seg_flags[3:2] == 2'b00 && s_reg.seg_flags[1] ==
      $past(17'({1'b0, s_reg.src_a[31:16]} + {1'b0, s_reg.src_b[31:16]}) >> 16))
    else $error("halfword lane flags wrong");

  a_seg_zero: assert property ( // see [RL2]
    s_reg.pending && split && !is_sub && s_reg.op != SAD_OP_ADD && !sw_st |=>
      s_reg.seg_flags == 4'h0)
    else $error("lane flags not cleared");

  // Word mode leaves the lane flags alone
  a_word_keeps: assert property ( // see [RL2]
    s_reg.pending && !split && !sw_st |=> $stable(s_reg.seg_flags))
    else $error("lane flags changed in word mode");

  // Positions: the reported bit qualifies and nothing below it does
  a_rmbc_pos: assert property ( // see [RL5]
    seq_run(SAD_OP_RMBC) and seq_hw_res and (rmbc_src != SAD_RST_WORD) |=>
      s_reg.result[31:5] == 27'h0 &&
      (($past(rmbc_src) >> s_reg.result[4:0]) & 32'h1) == 32'h1 &&
      ($past(rmbc_src) & ((32'h1 << s_reg.result[4:0]) - 32'h1)) == 32'h0)
    else $error("rightmost change position wrong");

  a_rmbc_ovf: assert property ( // see [RL6]
    seq_run(SAD_OP_RMBC) and !sw_st |=>
      s_reg.ovf == ($past(s_reg.src_a) == 32'h0 || $past(s_reg.src_a) == 32'hffff_ffff))
    else $error("change overflow wrong");

  a_rmo_pos: assert property ( // see [RL7]
    seq_run(SAD_OP_RMO) and seq_hw_res and (s_reg.src_a != 32'h0) |=>
      s_reg.result[31:5] == 27'h0 &&
      (($past(s_reg.src_a) >> s_reg.result[4:0]) & 32'h1) == 32'h1 &&
      ($past(s_reg.src_a) & ((32'h1 << s_reg.result[4:0]) - 32'h1)) == 32'h0)
    else $error("rightmost one position wrong");

  // Highest differing bit: the reported one is set and nothing above it
  a_lchg_pos: assert property ( // see [RL12]
    seq_run(SAD_OP_LCHG) and seq_hw_res and (lchg_src != SAD_RST_WORD) |=>
      s_reg.result[31:5] == 27'h0 && ($past(lchg_src) >> s_reg.result[4:0]) == 32'h1)
    else $error("leftmost change position wrong");

  // No change below the sign bit only when every bit agrees
  a_lchg_ovf: assert property ( // see [RL12]
    seq_run(SAD_OP_LCHG) and !sw_st |=>
      s_reg.ovf == ($past(s_reg.src_a) == 32'h0 || $past(s_reg.src_a) == 32'hffff_ffff))
    else $error("leftmost change overflow wrong");

  // Mask is one unbroken run of ones starting at bit 0
  a_mask_gen: assert property ( // see [RL11]
    seq_run(SAD_OP_MASK) and seq_hw_res |=>
      $countones(s_reg.result) == $past(s_reg.src_b[4:0]) &&
      ((s_reg.result + 32'h1) & s_reg.result) == 32'h0)
    else $error("mask wrong");

  // Both unsigned lane products, full 16 bits each
  a_split_mul: assert property ( // see [RL8]
    seq_run(SAD_OP_SMUL) and seq_hw_res and !s_reg.mul_signed |=>
      s_reg.result[31:16] == $past({8'h00, s_reg.src_a[15:8]} * {8'h00, s_reg.src_b[15:8]}) &&
      s_reg.result[15:0] == $past({8'h00, s_reg.src_a[7:0]} * {8'h00, s_reg.src_b[7:0]}))
    else $error("split product wrong");

  a_split_sgn: assert property ( // see [RL9]
    seq_run(SAD_OP_SMUL) and seq_hw_res and s_reg.mul_signed and s_reg.src_b[7] &&
      s_reg.src_a[7:0] != 8'h00 |=> s_reg.result[15])
    else $error("signed split product not negative");

  a_sw_wins: assert property ( // see [RL10]
    s_reg.pending && sw_st |=> s_reg.seg_flags == $past(hwdata[SAD_ST_SEG_LSB +: 4]) &&
      s_reg.ovf == $past(hwdata[SAD_ST_OVF]))
    else $error("software write lost to hardware");

endmodule : sad_top

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
// Compare and count; four-state equality, so an unknown matches only an unknown
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin err_count++; \
  $display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end
module testbench
  import sad_pkg::*;
;
  logic        hclk      = 1'b0;   // Core clock
  logic        hresetn   = 1'b0;   // Reset, active low
  logic        hsel      = 1'b0;   // Slave select
  logic [31:0] haddr     = '0;     // Byte address
  logic [1:0]  htrans    = 2'h0;   // Transfer type
  logic        hwrite    = 1'b0;   // Write strobe
  logic [31:0] hwdata    = '0;     // Write data
  logic [31:0] hrdata;             // Read data
  logic        hreadyout;          // Slave ready, also bus ready
  logic        hresp;              // Response
  int          err_count = 0;      // Mismatches
  int          n_tests   = 0;      // Comparisons
  int          cyc       = 0;      // Cycle count for the hang guard
  logic [3:0]  seg_q     = 4'h0;   // Expected segment flags, kept across ops
  logic [31:0] rd, er, es, ms;     // Read value, expected result, status, mask
  logic [31:0] tv [5] = '{32'h0, 32'hffff_ffff, 32'h0000_0100, 32'h8000_0000, 32'h7fff_fff0};

  sad_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp));

  // 100 MHz clock
  always #5 hclk = ~hclk;

  // Hang guard: about 500 cycles cover every test, so 20000 leaves wide margin
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  // Address phase held until ready is seen at an edge
  task automatic addr_ph(input logic [7:0] a, input logic w);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= {24'h0, a}; hwrite <= w; htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask : addr_ph

  // Single write: address phase, then data phase until ready
  task automatic ahb_wr(input logic [7:0] a, input logic [31:0] d);
    addr_ph(a, 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask : ahb_wr

  // Single read: data taken at the data phase edge
  task automatic ahb_rd(input logic [7:0] a, output logic [31:0] d);
    addr_ph(a, 1'b0);
    htrans <= 2'h0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask : ahb_rd

  // Two pipelined writes: second data phase lands on the first one's side effect
  task automatic wr_pair(input logic [7:0] a1, input logic [31:0] d1,
                         input logic [7:0] a2, input logic [31:0] d2);
    addr_ph(a1, 1'b1);
    hwdata <= d1; haddr <= {24'h0, a2};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0; hwdata <= d2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask : wr_pair

  // Reference model; also sets the compare mask for the status word
  task automatic ref_op(input logic [3:0] op, input logic [1:0] ln, input logic sg,
                        input logic [31:0] a, input logic [31:0] b);
    int w, p, q;
    logic [63:0] s, m;
    logic c, v;
    w = (ln == SAD_LANE_HALF) ? 16 : (ln == SAD_LANE_BYTE) ? 8 : 32;
    er = 32'h0; c = 1'b0; v = 1'b0; ms = 32'hf7;
    if (w < 32) seg_q = 4'h0;
    case (op)
      SAD_OP_ADD, SAD_OP_SUB: begin
        m = (64'h1 << w) - 64'h1;
        if (w == 32) ms = 32'hf5;
        else ms = 32'hf4;
        for (int i = 0; i < 32; i += w) begin
          s = ((a >> i) & m) + ((op == SAD_OP_SUB) ? (((~b) >> i) & m) + 64'h1 : (b >> i) & m);
          er = er | 32'((s & m) << i);
          if (w < 32) seg_q[i / w] = s[w];
          c = s[w];
        end
      end
      SAD_OP_RMO: begin
        er = 32'h20;
        for (int i = 31; i >= 0; i--) if (a[i]) er = i;
      end
      SAD_OP_RMBC: begin
        er = 32'h20; v = 1'b1;
        for (int i = 31; i >= 1; i--) if (a[i] != a[0]) begin er = i; v = 1'b0; end
      end
      SAD_OP_LCHG: begin
        er = 32'h20; v = 1'b1;
        for (int i = 0; i <= 30; i++) if (a[i] != a[31]) begin er = i; v = 1'b0; end
      end
      SAD_OP_MASK: er = 32'((64'h1 << b[4:0]) - 64'h1);
      default: begin
        for (int k = 0; k < 2; k++) begin
          p = a[8*k +: 8];
          q = sg ? int'(signed'(b[8*k +: 8])) : int'(b[8*k +: 8]);
          er[16*k +: 16] = 16'(p * q);
        end
      end
    endcase
    es = {24'h0, seg_q, 1'b0, (er == 32'h0), v, c};
  endtask : ref_op

  // Load operands, start the op, read back the result
  task automatic run_op(input logic [3:0] op, input logic [1:0] ln, input logic sg,
                        input logic [31:0] a, input logic [31:0] b);
    ahb_wr(SAD_OFF_SRC_A, a);
    ahb_wr(SAD_OFF_SRC_B, b);
    ahb_wr(SAD_OFF_CTRL, (32'h1 << SAD_CTRL_GO) | (32'(sg) << SAD_CTRL_SIGNED) |
           (32'(ln) << SAD_CTRL_LANE_LSB) | 32'(op));
    ref_op(op, ln, sg, a, b);
    ahb_rd(SAD_OFF_RESULT, rd);
  endtask : run_op

  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values, unmapped place, response code
    ahb_rd(SAD_OFF_STATUS, rd); `CHK(rd, SAD_RST_WORD)
    ahb_wr(8'h20, 32'hdead_beef);
    ahb_rd(8'h20, rd); `CHK(rd, 32'h0)
    `CHK(hresp, 1'b0)
    $display("test reset done");
    // Carries cross every byte boundary; all four lane codes, add and sub
    for (int l = 0; l < 4; l++) begin
      for (int o = 0; o < 2; o++) begin
        run_op(4'(o), 2'(l), 1'b0, 32'h80ff_80ff, 32'h8001_8001);
        `CHK(rd, er)
        ahb_rd(SAD_OFF_STATUS, rd); `CHK(rd & ms, es & ms)
      end
    end
    run_op(SAD_OP_SUB, SAD_LANE_BYTE, 1'b0, 32'h1234_5678, 32'h1234_5678);
    ahb_rd(SAD_OFF_STATUS, rd); `CHK(rd & ms, es & ms)
    $display("test split arithmetic done");
    // Bit detection, lanes rotated so split mode clears the flags
    for (int i = 0; i < 5; i++) begin
      for (int o = 2; o < 5; o++) begin
        run_op(4'(o), 2'(i % 3), 1'b0, tv[i], 32'h0);
        `CHK(rd, er)
        ahb_rd(SAD_OFF_STATUS, rd); `CHK(rd & ms, es & ms)
      end
    end
    $display("test bit detect done");
    // Mask counts at the edges, zero included; upper bits of the count ignored
    foreach (tv[i]) begin
      run_op(SAD_OP_MASK, SAD_LANE_WORD, 1'b0, 32'h0, (i == 4) ? 32'hffff_ffe0 : 32'(i * 8 - 1));
      `CHK(rd, er)
    end
    $display("test mask done");
    // Split multiply, both factor readings, negative second factor
    for (int g = 0; g < 2; g++) begin
      run_op(SAD_OP_SMUL, SAD_LANE_WORD, 1'(g), 32'h0000_ff03, 32'h0000_80fe);
      `CHK(rd, er)
      // Control reads back the op and factor reading, busy already clear
      ahb_rd(SAD_OFF_CTRL, rd); `CHK(rd, (32'(g) << SAD_CTRL_SIGNED) | 32'(SAD_OP_SMUL))
      ahb_rd(SAD_OFF_SRC_B, rd); `CHK(rd, 32'h0000_80fe)
    end
    $display("test split multiply done");
    // Status write lands in the same cycle as the op's update and must win
    ahb_wr(SAD_OFF_SRC_A, 32'h0);
    wr_pair(SAD_OFF_CTRL, (32'h1 << SAD_CTRL_GO) | 32'(SAD_OP_RMBC), SAD_OFF_STATUS, 32'ha5);
    ahb_rd(SAD_OFF_STATUS, rd); `CHK(rd & 32'hf7, 32'ha5)
    ahb_rd(SAD_OFF_RESULT, rd); `CHK(rd, 32'h20)
    ahb_wr(SAD_OFF_RESULT, 32'h0bad_f00d);
    ahb_rd(SAD_OFF_RESULT, rd); `CHK(rd, 32'h0bad_f00d)
    $display("test write precedence done");
    tally_and_finish();
  end
endmodule : testbench
